// ===== board_watchdog_timer.sv
// board watchdog timer: enable/refresh control register over apb, reset pulse on timeout
// assumes straps are static pins, sampled through a three-flop filter
`timescale 1ns/1ps
module board_watchdog_timer #(
  parameter int unsigned cap_pf = 47,
  parameter int unsigned pulse_cycles = 16,
  parameter int unsigned timeout_default_cycles =
    wdt_pkg::default_timeout_ms * wdt_pkg::cycles_per_ms,
  parameter int unsigned timeout_short_cycles =
    wdt_pkg::short_timeout_ms * wdt_pkg::cycles_per_ms,
  parameter int unsigned timeout_cap_cycles =
    (wdt_pkg::cap_ms_per_ref * cap_pf / wdt_pkg::cap_ref_pf) * wdt_pkg::cycles_per_ms
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watchdog_permit_strap,
  input wire logic [1:0] base_address_strap,
  input wire wdt_pkg::timeout_sel_t timeout_option,
  output logic wdt_reset_pulse
);
  import wdt_pkg::*;

  logic [2:0] permit_sync_reg;
  logic permit_reg;
  ctrl_bits_t ctrl_reg;
  logic [31:0] count_reg;
  logic [31:0] pulse_count_reg;
  logic pulse_reg;
  logic fired_reg;
  logic [31:0] limit;
  logic [11:0] base;
  logic [1:0] base_sync_reg [0:2];
  logic [1:0] base_strap_reg;
  timeout_sel_t opt_sync_reg [0:2];
  timeout_sel_t opt_strap_reg;
  logic acc, wr, hit_ctrl, hit_stat, refresh_toggle, running, expire;

  // base decode from the strap; code 3 falls back to the first base
  function automatic logic [11:0] base_of(input logic [1:0] s);
    unique case (s)
      2'h1: base_of = base_addr_1;
      2'h2: base_of = base_addr_2;
      default: base_of = base_addr_0;
    endcase
  endfunction

  assign base = base_of(base_strap_reg);
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign hit_ctrl = (paddr == base);
  assign hit_stat = (paddr == 12'(base + status_offset));
  assign pready = 1'b1; // zero wait states
  assign pslverr = acc && !(hit_ctrl || hit_stat);
  assign refresh_toggle = wr && hit_ctrl && (pwdata[refresh_bit] != ctrl_reg.refresh);
  assign running = ctrl_reg.enable && permit_reg;
  assign expire = running && (count_reg >= limit - 32'h1);

  // timeout select from the option straps
  always_comb begin
    unique case (opt_strap_reg)
      timeout_short: limit = 32'(timeout_short_cycles);
      timeout_capacitor: limit = 32'(timeout_cap_cycles);
      default: limit = 32'(timeout_default_cycles);
    endcase
  end

  // permit strap filter: change counts once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      permit_sync_reg <= 3'h0;
      permit_reg <= 1'b0;
    end else if (clk_en) begin
      permit_sync_reg <= {permit_sync_reg[1:0], watchdog_permit_strap};
      if (permit_sync_reg[2] == permit_sync_reg[1]) begin
        permit_reg <= permit_sync_reg[2];
      end
    end
  end

  // base and option straps are pins too: same three-flop filter, so a strap
  // moved while running takes effect a few cycles late, never half-way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_sync_reg[0] <= 2'h0;
      base_sync_reg[1] <= 2'h0;
      base_sync_reg[2] <= 2'h0;
      base_strap_reg <= 2'h0;
      opt_sync_reg[0] <= timeout_default;
      opt_sync_reg[1] <= timeout_default;
      opt_sync_reg[2] <= timeout_default;
      opt_strap_reg <= timeout_default;
    end else if (clk_en) begin
      base_sync_reg[0] <= base_address_strap;
      base_sync_reg[1] <= base_sync_reg[0];
      base_sync_reg[2] <= base_sync_reg[1];
      opt_sync_reg[0] <= timeout_option;
      opt_sync_reg[1] <= opt_sync_reg[0];
      opt_sync_reg[2] <= opt_sync_reg[1];
      if (base_sync_reg[2] == base_sync_reg[1]) begin
        base_strap_reg <= base_sync_reg[2];
      end
      if (opt_sync_reg[2] == opt_sync_reg[1]) begin
        opt_strap_reg <= opt_sync_reg[2];
      end
    end
  end

  // control register; the issued reset pulse clears enable at its end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ctrl_bits_t'(ctrl_reset[1:0]);
    end else if (clk_en) begin
      if (fired_reg) begin
        ctrl_reg.enable <= 1'b0;
      end else if (wr && hit_ctrl) begin
        ctrl_reg.enable <= pwdata[enable_bit];
        ctrl_reg.refresh <= pwdata[refresh_bit];
      end
    end
  end

  // timeout counter, restarted by each toggle of the refresh bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= zero_word;
    end else if (clk_en) begin
      if (!running || refresh_toggle || expire) begin
        count_reg <= zero_word;
      end else begin
        count_reg <= count_reg + 32'h1;
      end
    end
  end

  // reset pulse generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg <= 1'b0;
      pulse_count_reg <= zero_word;
      fired_reg <= 1'b0;
    end else if (clk_en) begin
      fired_reg <= 1'b0;
      if (expire && !pulse_reg) begin
        pulse_reg <= 1'b1;
        pulse_count_reg <= 32'(pulse_cycles) - 32'h1;
      end else if (pulse_reg) begin
        if (pulse_count_reg == zero_word) begin
          pulse_reg <= 1'b0;
          fired_reg <= 1'b1;
        end else begin
          pulse_count_reg <= pulse_count_reg - 32'h1;
        end
      end
    end
  end
  assign wdt_reset_pulse = pulse_reg;

  // read data: control bits, and status shows permit, running and the reset pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= zero_word;
    end else if (clk_en) begin
      if (psel && !penable && !pwrite) begin
        if (hit_ctrl) begin
          prdata <= 32'({ctrl_reg.refresh, ctrl_reg.enable});
        end else if (hit_stat) begin
          prdata <= 32'({pulse_reg, running, permit_reg});
        end else begin
          prdata <= zero_word;
        end
      end
    end
  end

  // assertions
  property p_strap_gate;
    @(posedge pclk) disable iff (!presetn)
    clk_en && !permit_reg |=> !expire;
  endproperty
  a_strap_gate: assert property (p_strap_gate) else $error("ran without strap");

  property p_pulse_on_expire;
    @(posedge pclk) disable iff (!presetn)
    clk_en && expire && !pulse_reg |=> pulse_reg;
  endproperty
  a_pulse_on_expire: assert property (p_pulse_on_expire) else $error("no pulse");

  property p_disable_after_pulse;
    @(posedge pclk) disable iff (!presetn)
    clk_en && fired_reg |=> !ctrl_reg.enable;
  endproperty
  a_disable_after_pulse: assert property (p_disable_after_pulse)
    else $error("still enabled");

  property p_refresh_restart;
    @(posedge pclk) disable iff (!presetn)
    clk_en && refresh_toggle |=> count_reg == zero_word;
  endproperty
  a_refresh_restart: assert property (p_refresh_restart) else $error("no restart");

  property p_enable_write;
    @(posedge pclk) disable iff (!presetn)
    clk_en && wr && hit_ctrl && !fired_reg |=> ctrl_reg.enable == $past(pwdata[enable_bit]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable lost");

  property p_no_pulse_idle;
    @(posedge pclk) disable iff (!presetn)
    !pulse_reg && !expire |=> !pulse_reg;
  endproperty
  a_no_pulse_idle: assert property (p_no_pulse_idle) else $error("spurious pulse");

  property p_decode_err;
    @(posedge pclk) disable iff (!presetn)
    acc && hit_ctrl |-> !pslverr;
  endproperty
  a_decode_err: assert property (p_decode_err) else $error("bad decode");

  property p_count_bound;
    @(posedge pclk) disable iff (!presetn)
    count_reg < limit;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("count overrun");

  c_refresh: cover property (@(posedge pclk) disable iff (!presetn) refresh_toggle && running);
  c_expire: cover property (@(posedge pclk) disable iff (!presetn) expire);
  c_fired: cover property (@(posedge pclk) disable iff (!presetn) fired_reg);
endmodule // board_watchdog_timer

// ===== board_watchdog_timer_test.sv
// bench for the board watchdog timer: apb host tasks and timeout tests
// assumes shortened timeouts and host_model beside the design
`timescale 1ns/1ps
module board_watchdog_timer_test;
  import wdt_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, pulse, err, permit = 1, clk_en = 1;
  logic [1:0] bsel = 2'h0;
  logic [11:0] paddr = 12'h000, base = 12'h190;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] shadow = 8'h00;
  timeout_sel_t topt = timeout_default;
  int pulses, len, fail_count = 0, checked = 0, cyc = 0, n;
  board_watchdog_timer #(.pulse_cycles(4), .timeout_default_cycles(50),
    .timeout_short_cycles(30), .timeout_cap_cycles(40)) board_watchdog_timer_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdog_permit_strap(permit),
    .base_address_strap(bsel), .timeout_option(topt), .wdt_reset_pulse(pulse));
  host_model host_model_i (.pclk(pclk), .wdt_reset_pulse(pulse), .pulses(pulses),
    .len(len));
  initial forever #2.5 pclk = ~pclk;
  task end_sim;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // writes are built from the shadow copy, never from readback
  task ctrl(input logic en, input logic rf);
    shadow[0] = en;
    shadow[1] = rf;
    apb(1, base, {24'h0, shadow});
  endtask
  task wait_pulse;
    n = 0;
    while (pulse !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task expire(input timeout_sel_t o, input logic [1:0] b, input int lim);
    int p0;
    p0 = pulses;
    topt <= o;
    bsel <= b;
    base = (b == 2'h1) ? base_addr_1 : (b == 2'h2) ? base_addr_2 : base_addr_0;
    repeat (6) @(posedge pclk);
    ctrl(1, shadow[1]);
    wait_pulse;
    cmp(n >= lim - 2 && n <= lim + 3, 1);
    repeat (8) @(posedge pclk);
    cmp(len, 4);
    cmp(pulses, p0 + 1);
    apb(0, base + status_offset, 0);
    cmp(rd[1], 0);
    cmp(rd[0], 1);
    $display("expiry test done, limit %0d", lim);
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h0a0, 0);
    cmp(err, 1);
    apb(0, base, 0);
    cmp(rd[1:0], 0);
    // a write while the clock enable is low must leave the register alone
    clk_en <= 0;
    ctrl(1, 0);
    clk_en <= 1;
    apb(0, base, 0);
    cmp(rd[1:0], 0);
    $display("decode, reset value and freeze tests done");
    permit <= 0;
    repeat (4) @(posedge pclk);
    ctrl(1, 0);
    wait_pulse;
    cmp(n, 200);
    ctrl(0, 0);
    $display("permit strap test done");
    permit <= 1;
    repeat (4) @(posedge pclk);
    ctrl(1, 0);
    for (int i = 0; i < 6; i++) begin
      repeat (35) @(posedge pclk);
      ctrl(1, ~shadow[1]);
    end
    cmp(pulses, 0);
    repeat (35) @(posedge pclk);
    ctrl(1, shadow[1]);
    wait_pulse;
    cmp(n < 20, 1);
    repeat (8) @(posedge pclk);
    $display("refresh test done");
    expire(timeout_default, 2'h0, 50);
    expire(timeout_short, 2'h1, 30);
    expire(timeout_capacitor, 2'h2, 40);
    expire(timeout_short, 2'h3, 30);
    ctrl(1, 0);
    repeat (10) @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    shadow = 8'h00;
    wait_pulse;
    cmp(n, 200);
    $display("mid-run reset test done");
    end_sim;
  end
endmodule // board_watchdog_timer_test

// ===== host_model.sv
// host side model: counts watchdog reset pulses and their length
// assumes one clock domain and an active high pulse
`timescale 1ns/1ps
module host_model (
  input wire logic pclk,
  input wire logic wdt_reset_pulse,
  output int pulses,
  output int len
);
  int run = 0;
  int pulse_total = 0;
  int last_len = 0;
  // length is taken as the pulse falls
  always @(posedge pclk) begin
    if (wdt_reset_pulse) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_len <= run;
      pulse_total <= pulse_total + 1;
      run <= 0;
    end
  end
  // one driver per output
  assign pulses = pulse_total;
  assign len = last_len;
endmodule // host_model

// ===== wdt_pkg.sv
// package for the board watchdog timer: register map, fields, timing
// assumes a 200 MHz pclk and an apb slave port
package wdt_pkg;
  localparam int unsigned clk_mhz = 200;
  // register base addresses selected by the base address strap
  localparam logic [11:0] base_addr_0 = 12'h190;
  localparam logic [11:0] base_addr_1 = 12'h290;
  localparam logic [11:0] base_addr_2 = 12'h390;
  localparam logic [11:0] status_offset = 12'h004;
  // control field positions
  localparam int unsigned enable_bit = 0;
  localparam int unsigned refresh_bit = 1;
  localparam logic [7:0] ctrl_reset = 8'h00;
  // timeouts in ms
  localparam int unsigned default_timeout_ms = 1600;
  localparam int unsigned short_timeout_ms = 100;
  localparam int unsigned cap_ms_per_ref = 400;
  localparam int unsigned cap_ref_pf = 47;
  localparam int unsigned cycles_per_ms = clk_mhz * 1000;
  localparam logic [31:0] zero_word = 32'h0000_0000;
  typedef enum logic [1:0] {
    timeout_default,
    timeout_short,
    timeout_capacitor
  } timeout_sel_t;
  typedef struct packed {
    logic refresh;
    logic enable;
  } ctrl_bits_t;
endpackage
